// ==== frs_pkg.sv ====
// Package with register map, field layout and constants of the rate/status/queue block
package frs_pkg;
  // ----------------------------------------
  // Register byte addresses (AXI4-Lite)
  // ----------------------------------------
  localparam logic [3:0] FRS_ADDR_CTRL = 4'h0;
  localparam logic [3:0] FRS_ADDR_STATUS = 4'h4;
  localparam logic [3:0] FRS_ADDR_QUEUE = 4'h8;
  localparam logic [3:0] FRS_ADDR_CORE = 4'hC;
  // ----------------------------------------
  // Rate register fields
  // ----------------------------------------
  localparam int FRS_BIT_SWRST = 7;
  localparam int FRS_BIT_SLEEP = 6;
  localparam int FRS_BIT_OSCOFF = 5;
  localparam int FRS_DLY_HI = 4;
  localparam int FRS_DLY_LO = 2;
  localparam int FRS_RATE_HI = 1;
  localparam int FRS_RATE_LO = 0;
  localparam logic [2:0] FRS_DLY_RST = 3'h0;
  localparam logic [1:0] FRS_RATE_RST = 2'h2;
  localparam logic [2:0] FRS_DLY_DEFAULT = 3'h0;
  localparam logic [2:0] FRS_DLY_OFF = 3'h7;
  localparam logic [1:0] FRS_RATE_1M = 2'h3;
  // Shift in 41.67 ns steps for rate-dependent default
  localparam logic [2:0] FRS_STEP_FAST = 3'h1;
  localparam logic [2:0] FRS_STEP_SLOW = 3'h3;
  // ----------------------------------------
  // Core control register fields (offset 0xC)
  // ----------------------------------------
  localparam int FRS_CORE_KEEP = 0;
  localparam int FRS_CORE_POLLED = 1;
  localparam int FRS_CORE_FULLQ = 2;
  localparam int FRS_CORE_START = 3;
  localparam int FRS_CORE_THR_LO = 4;
  localparam int FRS_CORE_THR_HI = 7;
  localparam int FRS_CORE_TRK_LO = 8;
  localparam int FRS_CORE_TRK_HI = 15;
  // ----------------------------------------
  // Status bits and example values
  // ----------------------------------------
  localparam int FRS_ST_PERMIT = 7;
  localparam int FRS_ST_DIR = 6;
  localparam int FRS_ST_POLLED = 5;
  localparam int FRS_ST_BUSY = 4;
  localparam logic [7:0] FRS_ST_IDLE = 8'h80;
  localparam int FRS_QUEUE_DEPTH = 16;
  localparam logic [1:0] FRS_RESP_OKAY = 2'h0;
  localparam logic [1:0] FRS_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    FRS_PH_IDLE = 2'b00,
    FRS_PH_CMD = 2'b01,
    FRS_PH_EXEC = 2'b11,
    FRS_PH_RES = 2'b10
  } frs_phase_e;
endpackage

// ==== frs_queue_mem.sv ====
// Byte memory of the command/data queue, registered read port
`timescale 1ns/100ps
module frs_queue_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock
  input wire logic aclk,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data_ff
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_ff <= mem[rd_addr];
  end
endmodule

// ==== frs_regs.sv ====
// Rate/power control, handshake status and command/data queue registers
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps

module frs_regs import frs_pkg::*; #(
  parameter int DEPTH = FRS_QUEUE_DEPTH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Controller core side: phase and seek state
  input wire logic core_cmd_accepted,
  input wire logic core_cmd_no_result,
  input wire logic core_exec_start,
  input wire logic core_result_start,
  input wire logic core_result_done,
  input wire logic [1:0] core_unit_seeking,
  // Controller core side: queue access
  input wire logic core_q_push,
  input wire logic [7:0] core_q_wdata,
  input wire logic core_q_pop,
  output logic [7:0] core_q_rdata_ff,
  output logic [4:0] core_q_level_ff,
  // Controller core side: control outputs
  output logic core_reset_ff,
  output logic powered_down_ff,
  output logic oscillator_off_ff,
  output logic [1:0] rate_select_ff,
  output logic [2:0] write_shift_delay_ff,
  output logic [2:0] shift_steps_ff,
  output logic [7:0] write_shift_delay_start_track_ff,
  output logic full_queue_mode_ff,
  output logic [3:0] queue_threshold_ff
);
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------
  // Bus slave state
  // ----------------------------------------
  logic aw_held_ff, nxt_aw_held;
  logic [3:0] aw_addr_ff, nxt_aw_addr;
  logic w_held_ff, nxt_w_held;
  logic [31:0] w_data_ff, nxt_w_data;
  logic [3:0] w_strb_ff, nxt_w_strb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic rd_pend_ff, nxt_rd_pend;
  logic [3:0] rd_addr_ff, nxt_rd_addr;

  // ----------------------------------------
  // Control and status state
  // ----------------------------------------
  logic osc_off_ff, nxt_osc_off;
  logic [1:0] rate_ff, nxt_rate;
  logic [2:0] dly_ff, nxt_dly;
  logic [2:0] steps_ff, nxt_steps;
  logic swrst_ff, nxt_swrst;
  logic pd_ff, nxt_pd;
  logic keep_ff, nxt_keep;
  logic polled_ff, nxt_polled;
  logic fullq_ff, nxt_fullq;
  logic [3:0] thr_ff, nxt_thr;
  logic [7:0] trk_ff, nxt_trk;
  frs_phase_e phase_ff, nxt_phase;
  logic [1:0] seek_ff, nxt_seek;
  logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [7:0] qrd;

  logic wr_go, rd_go, wr_ok, sw_reset, host_push, host_pop, do_push, do_pop;
  logic [7:0] status;

  assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
  assign rd_go = s_axi_arvalid && !rd_pend_ff && !rvalid_ff;
  assign wr_ok = wr_go && w_strb_ff[0];

  // Host pushes to or pops the queue only when the status permits it in that direction
  assign host_push = wr_ok && aw_addr_ff == FRS_ADDR_QUEUE && status[FRS_ST_PERMIT]
                     && !status[FRS_ST_DIR] && cnt_ff < 5'(DEPTH);
  assign host_pop = rd_go && s_axi_araddr == FRS_ADDR_QUEUE && status[FRS_ST_PERMIT]
                    && status[FRS_ST_DIR] && cnt_ff != 5'h0;
  assign do_push = (host_push || core_q_push) && cnt_ff < 5'(DEPTH);
  assign do_pop = (host_pop || core_q_pop) && cnt_ff != 5'h0;
  assign sw_reset = swrst_ff;

  // ----------------------------------------
  // Handshake status
  // ----------------------------------------
  always_comb begin
    status = 8'h00;
    status[FRS_ST_BUSY] = phase_ff != FRS_PH_IDLE;
    status[FRS_ST_POLLED] = polled_ff && phase_ff == FRS_PH_EXEC;
    // Port stays open in every phase, so DMA execution reads 90H
    status[FRS_ST_PERMIT] = !pd_ff && !core_reset_ff;
    status[FRS_ST_DIR] = phase_ff == FRS_PH_RES;
    status[1:0] = seek_ff;
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_held = w_held_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    nxt_rd_pend = 1'b0;
    nxt_rd_addr = rd_addr_ff;
    nxt_osc_off = osc_off_ff;
    nxt_rate = rate_ff;
    nxt_dly = dly_ff;
    nxt_swrst = 1'b0;
    nxt_pd = pd_ff;
    nxt_keep = keep_ff;
    nxt_polled = polled_ff;
    nxt_fullq = fullq_ff;
    nxt_thr = thr_ff;
    nxt_trk = trk_ff;
    nxt_phase = phase_ff;
    nxt_seek = core_unit_seeking;
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    nxt_cnt = cnt_ff;

    if (s_axi_awvalid && !aw_held_ff) begin
      nxt_aw_held = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_ff) begin
      nxt_w_held = 1'b1;
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = (aw_addr_ff == FRS_ADDR_STATUS) ? FRS_RESP_SLVERR : FRS_RESP_OKAY;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end

    // Rate register: all fields of one write act together
    if (wr_ok && aw_addr_ff == FRS_ADDR_CTRL) begin
      nxt_rate = w_data_ff[FRS_RATE_HI:FRS_RATE_LO];
      nxt_dly = w_data_ff[FRS_DLY_HI:FRS_DLY_LO];
      nxt_osc_off = w_data_ff[FRS_BIT_OSCOFF];
      nxt_swrst = w_data_ff[FRS_BIT_SWRST] || w_data_ff[FRS_BIT_SLEEP];
      if (w_data_ff[FRS_BIT_SLEEP]) begin
        nxt_pd = 1'b1;
      end else if (w_data_ff[FRS_BIT_SWRST]) begin
        nxt_pd = 1'b0;
      end
    end
    if (wr_ok && aw_addr_ff == FRS_ADDR_CORE) begin
      nxt_keep = w_data_ff[FRS_CORE_KEEP];
      nxt_polled = w_data_ff[FRS_CORE_POLLED];
      nxt_fullq = w_data_ff[FRS_CORE_FULLQ];
      nxt_thr = w_data_ff[FRS_CORE_THR_HI:FRS_CORE_THR_LO];
      // Powerdown is left only through a reset, never by a config write
      nxt_trk = w_data_ff[FRS_CORE_TRK_HI:FRS_CORE_TRK_LO];
    end

    // Read channel: queue data appear one cycle after the pop
    if (rd_go) begin
      nxt_rd_pend = 1'b1;
      nxt_rd_addr = s_axi_araddr;
    end
    if (rd_pend_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = FRS_RESP_OKAY;
      case (rd_addr_ff)
        FRS_ADDR_CTRL: nxt_rdata = 32'h0000_0000;
        FRS_ADDR_STATUS: nxt_rdata = {24'h000000, status};
        FRS_ADDR_QUEUE: nxt_rdata = {24'h000000, qrd};
        FRS_ADDR_CORE: nxt_rdata = {16'h0000, trk_ff, thr_ff, 1'b0, fullq_ff, polled_ff, keep_ff};
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = FRS_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end

    // Command phase tracking
    case (phase_ff)
      FRS_PH_IDLE: if (core_cmd_accepted) nxt_phase = FRS_PH_CMD;
      FRS_PH_CMD: begin
        if (core_cmd_no_result) begin
          nxt_phase = FRS_PH_IDLE;
        end else if (core_exec_start) begin
          nxt_phase = FRS_PH_EXEC;
        end else if (core_result_start) begin
          nxt_phase = FRS_PH_RES;
        end
      end
      FRS_PH_EXEC: if (core_result_start) nxt_phase = FRS_PH_RES;
      FRS_PH_RES: if (core_result_done) nxt_phase = FRS_PH_IDLE;
      default: nxt_phase = FRS_PH_IDLE;
    endcase

    // Queue pointers
    if (do_push) begin
      nxt_wp = wp_ff + AW'(1);
    end
    if (do_pop) begin
      nxt_rp = rp_ff + AW'(1);
    end
    nxt_cnt = cnt_ff + 5'(do_push) - 5'(do_pop);

    // Software reset idles the phase and, unless keep is set, clears queue, full-queue mode and threshold; rate, delay and oscillator bits stay
    if (sw_reset) begin
      nxt_phase = FRS_PH_IDLE;
      if (!keep_ff) begin
        nxt_fullq = 1'b0;
        nxt_thr = 4'h0;
        nxt_wp = '0;
        nxt_rp = '0;
        nxt_cnt = 5'h0;
      end
    end
  end

  // ----------------------------------------
  // Derived precompensation shift
  // ----------------------------------------
  always_comb begin
    if (dly_ff == FRS_DLY_OFF) begin
      nxt_steps = 3'h0;
    end else if (dly_ff == FRS_DLY_DEFAULT) begin
      nxt_steps = (rate_ff == FRS_RATE_1M) ? FRS_STEP_FAST : FRS_STEP_SLOW;
    end else begin
      nxt_steps = dly_ff;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 4'h0;
      w_held_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= FRS_RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= FRS_RESP_OKAY;
      rd_pend_ff <= 1'b0;
      rd_addr_ff <= 4'h0;
      osc_off_ff <= 1'b0;
      rate_ff <= FRS_RATE_RST;
      dly_ff <= FRS_DLY_RST;
      steps_ff <= FRS_STEP_SLOW;
      swrst_ff <= 1'b0;
      pd_ff <= 1'b0;
      keep_ff <= 1'b0;
      polled_ff <= 1'b0;
      fullq_ff <= 1'b0;
      thr_ff <= 4'h0;
      trk_ff <= 8'h00;
      phase_ff <= FRS_PH_IDLE;
      seek_ff <= 2'h0;
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= 5'h0;
    end else begin
      aw_held_ff <= nxt_aw_held;
      aw_addr_ff <= nxt_aw_addr;
      w_held_ff <= nxt_w_held;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      rd_pend_ff <= nxt_rd_pend;
      rd_addr_ff <= nxt_rd_addr;
      osc_off_ff <= nxt_osc_off;
      rate_ff <= nxt_rate;
      dly_ff <= nxt_dly;
      steps_ff <= nxt_steps;
      swrst_ff <= nxt_swrst;
      pd_ff <= nxt_pd;
      keep_ff <= nxt_keep;
      polled_ff <= nxt_polled;
      fullq_ff <= nxt_fullq;
      thr_ff <= nxt_thr;
      trk_ff <= nxt_trk;
      phase_ff <= nxt_phase;
      seek_ff <= nxt_seek;
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // Pop reads the head address; memory returns it one cycle later
  frs_queue_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
    .aclk(aclk),
    .wr_en(do_push),
    .wr_addr(wp_ff),
    .wr_data(host_push ? w_data_ff[7:0] : core_q_wdata),
    .rd_addr(rp_ff),
    .rd_data_ff(qrd)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_q_rdata_ff <= 8'h00;
      core_q_level_ff <= 5'h0;
      core_reset_ff <= 1'b0;
      powered_down_ff <= 1'b0;
      oscillator_off_ff <= 1'b0;
      rate_select_ff <= FRS_RATE_RST;
      write_shift_delay_ff <= FRS_DLY_RST;
      shift_steps_ff <= FRS_STEP_SLOW;
      write_shift_delay_start_track_ff <= 8'h00;
      full_queue_mode_ff <= 1'b0;
      queue_threshold_ff <= 4'h0;
    end else begin
      core_q_rdata_ff <= qrd;
      core_q_level_ff <= cnt_ff;
      core_reset_ff <= sw_reset;
      powered_down_ff <= pd_ff;
      oscillator_off_ff <= osc_off_ff;
      rate_select_ff <= rate_ff;
      write_shift_delay_ff <= dly_ff;
      shift_steps_ff <= steps_ff;
      write_shift_delay_start_track_ff <= trk_ff;
      full_queue_mode_ff <= fullq_ff;
      queue_threshold_ff <= thr_ff;
    end
  end

  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready = !w_held_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rd_pend_ff && !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
endmodule

// ==== frs_regs_props.sv ====
// Concurrent checks on the ports of the rate/status/queue register block
`timescale 1ns/100ps
module frs_regs_props import frs_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  // Core side
  input wire logic [4:0] core_q_level_ff,
  input wire logic core_reset_ff,
  input wire logic powered_down_ff,
  input wire logic oscillator_off_ff,
  input wire logic [1:0] rate_select_ff,
  input wire logic [2:0] write_shift_delay_ff,
  input wire logic [2:0] shift_steps_ff
);
  // ----
  // Read address tracking, expected shift
  // ----
  logic [3:0] ar_ff;
  logic [3:0] nxt_ar;
  logic [2:0] want_steps;
  logic st_rd;
  always_comb begin
    nxt_ar = ar_ff;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_ar = s_axi_araddr;
    end
    st_rd = s_axi_rvalid && ar_ff == FRS_ADDR_STATUS;
    want_steps = write_shift_delay_ff;
    if (write_shift_delay_ff == FRS_DLY_OFF) begin
      want_steps = 3'h0;
    end else if (write_shift_delay_ff == FRS_DLY_DEFAULT) begin
      want_steps = (rate_select_ff == FRS_RATE_1M) ? FRS_STEP_FAST : FRS_STEP_SLOW;
    end
  end
  always_ff @(posedge aclk) begin
    ar_ff <= nxt_ar;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_self_clear: assert property (core_reset_ff |=> !core_reset_ff)
    else $error("core reset pulse too long");
  a_fields_by_write: assert property (!$stable({oscillator_off_ff, rate_select_ff, write_shift_delay_ff})
    |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("rate fields moved without a write");
  a_pd_enter: assert property ($rose(powered_down_ff)
    |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("powerdown without a write");
  a_pd_leave: assert property ($fell(powered_down_ff)
    |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("powerdown left without reset");
  a_ctrl_reads_zero: assert property (s_axi_rvalid && ar_ff == FRS_ADDR_CTRL
    |-> s_axi_rdata == 32'h0 && s_axi_rresp == FRS_RESP_OKAY) else $error("rate register readable");
  a_status_unused: assert property (st_rd |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[3:2] == 2'h0)
    else $error("status unused bits set");
  a_pd_no_permit: assert property (st_rd && powered_down_ff && $past(powered_down_ff, 3)
    |-> !s_axi_rdata[FRS_ST_PERMIT]) else $error("transfer permitted in powerdown");
  a_result_busy: assert property (st_rd && (s_axi_rdata[FRS_ST_DIR] || s_axi_rdata[FRS_ST_POLLED])
    |-> s_axi_rdata[FRS_ST_BUSY]) else $error("phase shown without busy");
  a_shift_map: assert property ($stable(write_shift_delay_ff) && $stable(rate_select_ff)
    |-> shift_steps_ff == want_steps) else $error("wrong effective shift");
  a_queue_bound: assert property (core_q_level_ff <= 5'h10)
    else $error("queue level above depth");
endmodule

bind frs_regs frs_regs_props u_props (.*);

// ==== frs_core_model.sv ====
// Behavioural controller core facing the register block
`timescale 1ns/100ps
module frs_core_model (
  // Clock
  input wire logic aclk,
  // Requests from the bench
  input wire logic [2:0] op,
  input wire logic [7:0] byte_in,
  input wire logic [1:0] seek_in,
  // Core strobes and levels
  output logic acc_ff,
  output logic nores_ff,
  output logic exec_ff,
  output logic res_ff,
  output logic done_ff,
  output logic push_ff,
  output logic pop_ff,
  output logic [7:0] byte_ff,
  output logic [1:0] seek_ff
);
  // Each request becomes one single-cycle strobe
  always_ff @(posedge aclk) begin
    acc_ff <= (op == 3'h1);
    nores_ff <= (op == 3'h2);
    exec_ff <= (op == 3'h3);
    res_ff <= (op == 3'h4);
    done_ff <= (op == 3'h5);
    push_ff <= (op == 3'h6);
    pop_ff <= (op == 3'h7);
    // Data is only meaningful with the push strobe, so it is scrambled otherwise
    byte_ff <= (op == 3'h6) ? byte_in : ~byte_in;
    seek_ff <= seek_in;
  end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the rate/status/queue register block
`timescale 1ns/100ps
module testbench import frs_pkg::*; ;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, core_unit_seeking, rate_select_ff;
  logic [31:0] s_axi_rdata;
  logic core_cmd_accepted, core_cmd_no_result, core_exec_start, core_result_start, core_result_done;
  logic core_q_push, core_q_pop, core_reset_ff, powered_down_ff, oscillator_off_ff, full_queue_mode_ff;
  logic [7:0] core_q_wdata, core_q_rdata_ff, write_shift_delay_start_track_ff;
  logic [4:0] core_q_level_ff;
  logic [2:0] write_shift_delay_ff, shift_steps_ff;
  logic [3:0] queue_threshold_ff;
  logic [2:0] op = 3'h0;
  logic [7:0] byte_in = 8'h0;
  logic [1:0] seek_in = 2'h0;
  logic [31:0] seed = 32'h9AA4EB93;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int rst_seen = 0;
  int n;

  frs_regs u_dut (.*);
  frs_core_model u_core (.aclk(aclk), .op(op), .byte_in(byte_in), .seek_in(seek_in), .acc_ff(core_cmd_accepted),
    .nores_ff(core_cmd_no_result), .exec_ff(core_exec_start), .res_ff(core_result_start),
    .done_ff(core_result_done), .push_ff(core_q_push), .pop_ff(core_q_pop), .byte_ff(core_q_wdata),
    .seek_ff(core_unit_seeking));

  initial begin
    forever #25 aclk = ~aclk;
  end
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [2:0] steps(input logic [4:0] f);
    if (f[4:2] == 3'h7) return 3'h0;
    if (f[4:2] != 3'h0) return f[4:2];
    return (f[1:0] == 2'h3) ? 3'h1 : 3'h3;
  endfunction
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] r);
    logic aw_t, w_t, b_t;
    exp_b.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_t = s_axi_awready;
      w_t = s_axi_wready;
      b_t = s_axi_bvalid;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end while (!b_t);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    logic ar_t, r_t;
    exp_r.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_t = s_axi_arready;
      r_t = s_axi_rvalid;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end while (!r_t);
    s_axi_rready <= 1'b0;
  endtask
  task automatic core(input logic [2:0] v);
    @(posedge aclk);
    op <= v;
    @(posedge aclk);
    op <= 3'h0;
    tick(3);
  endtask
  task automatic hw_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    tick(10);
    aresetn <= 1'b1;
    tick(2);
    chk(34'({oscillator_off_ff, powered_down_ff, rate_select_ff, write_shift_delay_ff, shift_steps_ff,
      full_queue_mode_ff, write_shift_delay_start_track_ff}), 34'({4'h2, 3'h0, 3'h3, 1'b0, 8'h0}));
  endtask
  // ----
  // Result watcher and timeout
  // ----
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (core_reset_ff === 1'b1) rst_seen <= rst_seen + 1;
    if (s_axi_rvalid === 1'b1 && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready) chk(34'(s_axi_bresp), 34'(exp_b.pop_front()));
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // ----
  // Main sequence
  // ----
  initial begin
    hw_reset();
    rd(FRS_ADDR_CTRL, 34'h0);
    wr(FRS_ADDR_STATUS, 16'h00FF, FRS_RESP_SLVERR);
    rd(FRS_ADDR_STATUS, {FRS_RESP_OKAY, 32'h80});
    rd(4'h2, {FRS_RESP_SLVERR, 32'h0});
    for (int i = 0; i < 32; i++) begin
      wr(FRS_ADDR_CTRL, 16'(i), FRS_RESP_OKAY);
      tick(2);
      chk(34'({rate_select_ff, write_shift_delay_ff, shift_steps_ff}), 34'({i[1:0], i[4:2], steps(i[4:0])}));
    end
    wr(FRS_ADDR_CORE, 16'h05A4, FRS_RESP_OKAY);
    tick(2);
    chk(34'({full_queue_mode_ff, queue_threshold_ff, write_shift_delay_start_track_ff}), 34'({1'b1, 4'hA, 8'h05}));
    n = rst_seen;
    wr(FRS_ADDR_CTRL, 16'h004E, FRS_RESP_OKAY);
    tick(4);
    chk(34'({powered_down_ff, 8'(rst_seen - n)}), 34'({1'b1, 8'h01}));
    rd(FRS_ADDR_STATUS, {FRS_RESP_OKAY, 32'h0});
    wr(FRS_ADDR_CTRL, 16'h002E, FRS_RESP_OKAY);
    tick(4);
    chk(34'({powered_down_ff, oscillator_off_ff}), 34'h3);
    wr(FRS_ADDR_CORE, 16'h0004, FRS_RESP_OKAY);
    n = rst_seen;
    wr(FRS_ADDR_CTRL, 16'h00AE, FRS_RESP_OKAY);
    tick(4);
    chk(34'({powered_down_ff, oscillator_off_ff, full_queue_mode_ff, rate_select_ff, write_shift_delay_ff,
      8'(rst_seen - n)}), 34'({1'b0, 1'b1, 1'b0, 2'h2, 3'h3, 8'h01}));
    wr(FRS_ADDR_CTRL, 16'h000E, FRS_RESP_OKAY);
    tick(2);
    chk(34'(oscillator_off_ff), 34'h0);
    wr(FRS_ADDR_CORE, 16'h0005, FRS_RESP_OKAY);
    wr(FRS_ADDR_CTRL, 16'h0082, FRS_RESP_OKAY);
    tick(4);
    chk(34'({full_queue_mode_ff, powered_down_ff, rate_select_ff}), 34'({1'b1, 1'b0, 2'h2}));
    core(3'h1);
    rd(FRS_ADDR_STATUS, {FRS_RESP_OKAY, 32'h90});
    seed = lfsr(seed);
    wr(FRS_ADDR_QUEUE, {8'h0, seed[7:0]}, FRS_RESP_OKAY);
    tick(3);
    chk(34'({core_q_level_ff, core_q_rdata_ff}), 34'({5'h01, seed[7:0]}));
    core(3'h7);
    core(3'h4);
    rd(FRS_ADDR_STATUS, {FRS_RESP_OKAY, 32'hD0});
    wr(FRS_ADDR_QUEUE, 16'h0055, FRS_RESP_OKAY);
    seed = lfsr(seed);
    byte_in <= seed[7:0];
    core(3'h6);
    chk(34'(core_q_level_ff), 34'h1);
    rd(FRS_ADDR_QUEUE, {FRS_RESP_OKAY, 24'h0, seed[7:0]});
    tick(2);
    chk(34'(core_q_level_ff), 34'h0);
    core(3'h5);
    rd(FRS_ADDR_STATUS, {FRS_RESP_OKAY, 32'h80});
    core(3'h1);
    core(3'h2);
    rd(FRS_ADDR_STATUS, {FRS_RESP_OKAY, 32'h80});
    core(3'h1);
    core(3'h3);
    rd(FRS_ADDR_STATUS, {FRS_RESP_OKAY, 32'h90});
    core(3'h4);
    core(3'h5);
    wr(FRS_ADDR_CORE, 16'h0002, FRS_RESP_OKAY);
    core(3'h1);
    core(3'h3);
    rd(FRS_ADDR_STATUS, {FRS_RESP_OKAY, 32'hB0});
    core(3'h4);
    core(3'h5);
    seek_in <= 2'h3;
    tick(3);
    rd(FRS_ADDR_STATUS, {FRS_RESP_OKAY, 32'h83});
    seek_in <= 2'h1;
    tick(3);
    rd(FRS_ADDR_STATUS, {FRS_RESP_OKAY, 32'h81});
    seek_in <= 2'h0;
    wr(FRS_ADDR_CTRL, 16'h005F, FRS_RESP_OKAY);
    wr(FRS_ADDR_CTRL, 16'h003F, FRS_RESP_OKAY);
    wr(FRS_ADDR_CORE, 16'h0004, FRS_RESP_OKAY);
    hw_reset();
    rd(FRS_ADDR_STATUS, {FRS_RESP_OKAY, 32'h80});
    wrap_up();
  end
endmodule
